// >>> src/bbcfg_pkg.sv
// Constants, field layouts and carrier types of the converter register bank.
// Assumes a simple byte register port on the same clock as the bank.
package bbcfg_pkg;
	localparam logic [7:0] addr_config = 8'h01;
	localparam logic [7:0] addr_flags = 8'h02;
	localparam logic [7:0] addr_identity = 8'h03;
	localparam logic [7:0] addr_setpoint_a = 8'h04;
	localparam logic [7:0] addr_setpoint_b = 8'h05;
	localparam int bit_reserved_hi = 7;
	localparam int bit_range = 6;
	localparam int bit_enable = 5;
	localparam int bit_reserved_lo = 4;
	localparam int bit_forced = 3;
	localparam int bit_ramp = 2;
	localparam int bit_overtemp = 1;
	localparam int bit_output_good = 0;
	localparam logic [7:0] config_reset_base = 8'h00;
	localparam logic [6:0] setpoint_a_reset = 7'h3c;
	localparam logic [6:0] setpoint_b_reset = 7'h42;
	localparam logic [1:0] flags_reset = 2'h0;
	// Identity fields; maker value is arbitrary
	localparam logic [3:0] identity_maker = 4'h5;
	localparam logic [1:0] identity_major = 2'h1;
	localparam logic [1:0] identity_minor = 2'h0;
	localparam int sync_stages = 2;

	typedef enum logic [1:0] {
		bbcfg_slew_1v = 2'h0,
		bbcfg_slew_2v5 = 2'h1,
		bbcfg_slew_5v = 2'h2,
		bbcfg_slew_10v = 2'h3
	} bbcfg_slew_t;

	typedef struct packed {
		logic reserved_hi;
		logic high_span;
		logic converter_on;
		logic reserved_lo;
		logic forced_pulse_mode;
		logic ramp_pulse_mode;
		bbcfg_slew_t slew;
	} bbcfg_config_t;

	typedef struct packed {
		logic high_span;
		logic converter_on;
		logic forced_pulse_mode;
		logic ramp_pulse_mode;
		bbcfg_slew_t slew;
		logic [6:0] setpoint_code;
	} bbcfg_drive_t;
endpackage

// >>> src/bbcfg_regs.sv
// Register bank of the buck-boost converter: config, flags, identity, setpoints.
// Assumes a serial front end on the same clock that gives one-cycle strobes,
// and analog events (overtemp, power-not-good, select pin) arriving async.
module bbcfg_regs #(
	parameter logic enable_reset = 1'b1
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic supply_ok,
	input wire logic chip_enable,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic overtemp_in,
	input wire logic power_bad_in,
	input wire logic setpoint_select_pin,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	output bbcfg_pkg::bbcfg_drive_t drive
);
	logic overtemp_s;
	logic power_bad_s;
	logic select_s;
	logic supply_ok_s;
	logic chip_enable_s;
	logic volatile_clear;
	bbcfg_pkg::bbcfg_config_t config_q;
	bbcfg_pkg::bbcfg_config_t next_config_q;
	bbcfg_pkg::bbcfg_config_t config_reset;
	logic [6:0] setpoint_a;
	logic [6:0] next_setpoint_a;
	logic [6:0] setpoint_b;
	logic [6:0] next_setpoint_b;
	logic overtemp_flag;
	logic next_overtemp_flag;
	logic output_good_flag;
	logic next_output_good_flag;
	logic [7:0] next_reg_rdata;
	logic next_reg_rvalid;
	bbcfg_pkg::bbcfg_drive_t next_drive;
	logic [7:0] read_mux;

	// Every analog level and both supply pins pass two flops first
	bbcfg_sync u_sync_ot (
		.clock(clock),
		.rst_b(rst_b),
		.din(overtemp_in),
		.dout(overtemp_s)
	);

	bbcfg_sync u_sync_pb (
		.clock(clock),
		.rst_b(rst_b),
		.din(power_bad_in),
		.dout(power_bad_s)
	);

	bbcfg_sync u_sync_sel (
		.clock(clock),
		.rst_b(rst_b),
		.din(setpoint_select_pin),
		.dout(select_s)
	);

	bbcfg_sync u_sync_uv (
		.clock(clock),
		.rst_b(rst_b),
		.din(supply_ok),
		.dout(supply_ok_s)
	);

	bbcfg_sync u_sync_en (
		.clock(clock),
		.rst_b(rst_b),
		.din(chip_enable),
		.dout(chip_enable_s)
	);

	// Supply loss or enable low wipes every volatile register
	// Wipe lags the pins by the two synchroniser flops
	assign volatile_clear = !supply_ok_s || !chip_enable_s;

	// Reset and volatile clear share one synchronous path
	logic wipe;
	assign wipe = !rst_b || volatile_clear;

	always_comb begin
		config_reset = bbcfg_pkg::config_reset_base;
		config_reset.converter_on = enable_reset;
	end

	always_comb begin
		read_mux = 8'h00;
		unique case (reg_addr)
			bbcfg_pkg::addr_config: read_mux = config_q;
			bbcfg_pkg::addr_flags: begin
				read_mux[bbcfg_pkg::bit_overtemp] = overtemp_flag;
				read_mux[bbcfg_pkg::bit_output_good] = output_good_flag;
			end
			bbcfg_pkg::addr_identity: read_mux = {bbcfg_pkg::identity_maker,
				bbcfg_pkg::identity_major, bbcfg_pkg::identity_minor};
			bbcfg_pkg::addr_setpoint_a: read_mux = {1'b0, setpoint_a};
			bbcfg_pkg::addr_setpoint_b: read_mux = {1'b0, setpoint_b};
			default: read_mux = 8'h00;
		endcase
	end

	// Config register; the whole byte is stored, reserved bits included
	always_comb begin
		next_config_q = config_q;
		if (reg_write && reg_addr == bbcfg_pkg::addr_config) begin
			// Reserved bits kept as written; the host keeps them zero
			next_config_q = reg_wdata;
		end
		if (wipe) begin
			next_config_q = config_reset;
		end
	end

	always_ff @(posedge clock) begin
		config_q <= next_config_q;
	end

	// Setpoints; bit 7 is not stored, so it always reads zero
	always_comb begin
		next_setpoint_a = setpoint_a;
		next_setpoint_b = setpoint_b;
		if (reg_write) begin
			unique case (reg_addr)
				bbcfg_pkg::addr_setpoint_a: next_setpoint_a = reg_wdata[6:0];
				bbcfg_pkg::addr_setpoint_b: next_setpoint_b = reg_wdata[6:0];
				// Flags, identity and undecoded addresses ignore writes
				default: ;
			endcase
		end
		if (wipe) begin
			next_setpoint_a = bbcfg_pkg::setpoint_a_reset;
			next_setpoint_b = bbcfg_pkg::setpoint_b_reset;
		end
	end

	always_ff @(posedge clock) begin
		setpoint_a <= next_setpoint_a;
		setpoint_b <= next_setpoint_b;
	end

	// Flags latch a live condition; a read clears only once it has gone.
	// Set beats clear, so an event in the cycle of the read survives.
	always_comb begin
		next_overtemp_flag = overtemp_flag;
		if (reg_read && reg_addr == bbcfg_pkg::addr_flags) begin
			next_overtemp_flag = 1'b0;
		end
		if (overtemp_s) begin
			next_overtemp_flag = 1'b1;
		end
		if (wipe) begin
			next_overtemp_flag = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		overtemp_flag <= next_overtemp_flag;
	end

	// Flag bit 0 set means a power-not-good event was seen
	always_comb begin
		next_output_good_flag = output_good_flag;
		if (reg_read && reg_addr == bbcfg_pkg::addr_flags) begin
			next_output_good_flag = 1'b0;
		end
		if (power_bad_s) begin
			next_output_good_flag = 1'b1;
		end
		if (wipe) begin
			next_output_good_flag = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		output_good_flag <= next_output_good_flag;
	end

	// Read answer; data holds until the next read or wipe so a slow host can take it
	// Read and write in one cycle return the old value from read_mux
	always_comb begin
		next_reg_rvalid = reg_read;
		next_reg_rdata = reg_read ? read_mux : reg_rdata;
		// A wiped bank gives no answer rather than stale data
		if (wipe) begin
			next_reg_rvalid = 1'b0;
			next_reg_rdata = 8'h00;
		end
	end

	always_ff @(posedge clock) begin
		reg_rvalid <= next_reg_rvalid;
		reg_rdata <= next_reg_rdata;
	end

	// Drive follows the next register values, so it moves with the write edge
	always_comb begin
		next_drive.high_span = next_config_q.high_span;
		next_drive.converter_on = next_config_q.converter_on;
		next_drive.forced_pulse_mode = next_config_q.forced_pulse_mode;
		next_drive.ramp_pulse_mode = next_config_q.ramp_pulse_mode;
		next_drive.slew = next_config_q.slew;
		// Code picked by the pin; the span offset is applied on the analog side
		next_drive.setpoint_code = next_setpoint_a;
		if (select_s && rst_b) begin
			next_drive.setpoint_code = next_setpoint_b;
		end
	end

	// Registered so every converter control leaves a flop
	always_ff @(posedge clock) begin
		drive <= next_drive;
	end
endmodule // bbcfg_regs

// >>> src/bbcfg_sync.sv
// Two-stage synchroniser for one asynchronous level.
// Assumes the level may change at any time relative to clock.
module bbcfg_sync (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic din,
	output logic dout
);
	logic stage1;
	logic next_stage1;
	logic next_dout;

	always_comb begin
		next_stage1 = din;
		next_dout = stage1;
		if (!rst_b) begin
			next_stage1 = 1'b0;
			next_dout = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		stage1 <= next_stage1;
		dout <= next_dout;
	end
endmodule // bbcfg_sync

// >>> verif/bbcfg_host.sv
// Host model making single-byte register accesses on the falling edge.
// Assumes the bank answers a read exactly one cycle after taking it.
module bbcfg_host (
	input wire logic clock,
	input wire logic reg_rvalid,
	input wire logic [7:0] reg_rdata,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_write,
	output logic reg_read
);
	timeunit 1ns;
	timeprecision 1ns;
	logic to = 1'b0;
	initial {reg_addr, reg_wdata, reg_write, reg_read} = 18'h0_0000;
	// Released lines show the inverse, never the stale value
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		{reg_addr, reg_wdata, reg_write} = {a, d, 1'b1};
		@(negedge clock);
		{reg_addr, reg_wdata, reg_write} = {~a, ~d, 1'b0};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		@(negedge clock);
		{reg_addr, reg_read} = {a, 1'b1};
		@(negedge clock);
		{reg_addr, reg_read} = {~a, 1'b0};
		to = (reg_rvalid !== 1'b1);
		q = reg_rdata;
	endtask
endmodule // bbcfg_host

// >>> verif/bbcfg_regs_props.sv
// Checker for the converter register bank, bound to its ports.
// Assumes one-cycle strobes and inputs that change away from the rising edge.
module bbcfg_regs_props #(
	parameter logic enable_reset = 1'b1
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic supply_ok,
	input wire logic chip_enable,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic overtemp_in,
	input wire logic power_bad_in,
	input wire logic setpoint_select_pin,
	input wire logic reg_rvalid,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire bbcfg_pkg::bbcfg_drive_t drive
);
	logic [1:0] calm;
	logic [1:0] next_calm;
	// Synchronisers lag, so writes only count once inputs sat still
	always_comb next_calm = (!rst_b || !supply_ok || !chip_enable || setpoint_select_pin) ?
		2'h0 : calm + {1'b0, calm != 2'h3};
	always_ff @(posedge clock) calm <= next_calm;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	rvalid_follow_a: assert property (reg_read |=> reg_rvalid)
		else $error("read not answered");
	rvalid_only_a: assert property (!reg_read |=> !reg_rvalid)
		else $error("answer without read");
	unmapped_zero_a: assert property (reg_read && (reg_addr == 0 || reg_addr > 5) |=>
		reg_rdata == 8'h00) else $error("unmapped read not zero");
	identity_read_a: assert property (reg_read && reg_addr == 3 |=> reg_rdata ==
		{bbcfg_pkg::identity_maker, bbcfg_pkg::identity_major, bbcfg_pkg::identity_minor})
		else $error("identity wrong");
	setpoint_top_a: assert property (reg_read && reg_addr inside {4, 5} |=> !reg_rdata[7])
		else $error("setpoint bit 7 set");
	config_drive_a: assert property (reg_write && reg_addr == 1 && calm == 3 |=>
		drive[12:7] == {$past(reg_wdata[6:5]), $past(reg_wdata[3:0])}) else $error("config drive");
	setpoint_drive_a: assert property (reg_write && reg_addr == 4 && calm == 3 |=>
		drive.setpoint_code == $past(reg_wdata[6:0])) else $error("setpoint drive");
	volatile_clear_a: assert property (!(supply_ok && chip_enable) [*4] |=>
		drive[12:7] == {1'b0, enable_reset, 4'h0}) else $error("volatile clear");
endmodule // bbcfg_regs_props

// >>> verif/tb_buck_boost_config_regs.sv
// Self-checking bench for the converter register bank.
// Assumes the host model drives the register port; bench drives analog levels.
module tb_buck_boost_config_regs;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic er = 1'b0;
	logic clock = 1'b0, rst_b = 1'b0, supply_ok = 1'b1, chip_enable = 1'b1;
	logic overtemp_in = 1'b0, power_bad_in = 1'b0, setpoint_select_pin = 1'b0;
	logic reg_write, reg_read, reg_rvalid;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, q, c, w;
	bbcfg_pkg::bbcfg_drive_t drive;
	int errors = 0, checks = 0;
	always #10 clock = ~clock;
	bbcfg_regs #(.enable_reset(er)) dut_u (
		.clock(clock),
		.rst_b(rst_b),
		.supply_ok(supply_ok),
		.chip_enable(chip_enable),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_write(reg_write),
		.reg_read(reg_read),
		.overtemp_in(overtemp_in),
		.power_bad_in(power_bad_in),
		.setpoint_select_pin(setpoint_select_pin),
		.reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid),
		.drive(drive)
	);
	bbcfg_host host_u (
		.clock(clock),
		.reg_rvalid(reg_rvalid),
		.reg_rdata(reg_rdata),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_write(reg_write),
		.reg_read(reg_read)
	);
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e) begin
			errors++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic results();
		if (errors == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		host_u.rd(a, q);
		if (host_u.to) begin
			errors++;
			$display("Error %0t: read not answered", $time);
			results();
		end else begin
			chk({8'h00, q}, {8'h00, e});
		end
	endtask
	function automatic logic [7:0] rv(input int a);
		case (a)
			1: return {2'h0, er, 5'h00};
			3: return {bbcfg_pkg::identity_maker, bbcfg_pkg::identity_major, 2'h0};
			4: return 8'h3c;
			5: return 8'h42;
			default: return 8'h00;
		endcase
	endfunction
	function automatic logic [15:0] drv(input logic [7:0] f, input logic [6:0] s);
		return {3'h0, f[6:5], f[3:0], s};
	endfunction
	initial begin
		void'($urandom(32'h74cd_23dc));
		repeat (8) @(negedge clock);
		rst_b = 1;
		repeat (4) @(negedge clock);
		chk({3'h0, drive}, drv(rv(1), 7'h3c));
		for (int a = 0; a < 8; a++) rdc(a[7:0], rv(a));
		for (int i = 0; i < 12; i++) begin
			c = (8'($urandom) & 8'h6c) | {6'h00, i[1:0]};
			w = 8'($urandom);
			host_u.wr(8'h01, c);
			host_u.wr(8'h04, w);
			@(negedge clock);
			chk({3'h0, drive}, drv(c, w[6:0]));
			rdc(8'h01, c);
			rdc(8'h04, {1'b0, w[6:0]});
		end
		host_u.wr(8'h02, 8'hff);
		host_u.wr(8'h03, 8'hff);
		host_u.wr(8'h05, ~w);
		rdc(8'h03, rv(3));
		rdc(8'h02, 8'h00);
		rdc(8'h05, {1'b0, ~w[6:0]});
		setpoint_select_pin = 1'b1;
		repeat (4) @(negedge clock);
		chk({3'h0, drive}, drv(c, ~w[6:0]));
		{overtemp_in, power_bad_in, setpoint_select_pin} = 3'h6;
		repeat (5) @(negedge clock);
		rdc(8'h02, 8'h03);
		rdc(8'h02, 8'h03);
		overtemp_in = 1'b0;
		repeat (5) @(negedge clock);
		rdc(8'h02, 8'h03);
		rdc(8'h02, 8'h01);
		power_bad_in = 1'b0;
		repeat (5) @(negedge clock);
		rdc(8'h02, 8'h01);
		rdc(8'h02, 8'h00);
		for (int k = 0; k < 2; k++) begin
			{supply_ok, chip_enable} = k ? 2'h1 : 2'h2;
			repeat (5) @(negedge clock);
			{supply_ok, chip_enable} = 2'h3;
			repeat (4) @(negedge clock);
			rdc(8'h01, rv(1));
			rdc(8'h05, rv(5));
			host_u.wr(8'h01, 8'h6f);
		end
		rst_b = 1'b0;
		repeat (2) @(negedge clock);
		rst_b = 1'b1;
		repeat (4) @(negedge clock);
		rdc(8'h01, rv(1));
		rdc(8'h04, rv(4));
		results();
	end
endmodule // tb_buck_boost_config_regs
bind bbcfg_regs bbcfg_regs_props #(.enable_reset(enable_reset)) props_u (
	.clock(clock),
	.rst_b(rst_b),
	.supply_ok(supply_ok),
	.chip_enable(chip_enable),
	.reg_write(reg_write),
	.reg_read(reg_read),
	.overtemp_in(overtemp_in),
	.power_bad_in(power_bad_in),
	.setpoint_select_pin(setpoint_select_pin),
	.reg_rvalid(reg_rvalid),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata),
	.drive(drive)
);
